// >>> power_switch_ctrl_pkg.sv
// shared constants and types of the control pin block
`default_nettype none
package power_switch_ctrl_pkg;

    // ******************************************
    // sizes
    // ******************************************
    localparam int NUM_CHANNELS = 8;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int SYNC_STAGES = 2;

    // ******************************************
    // register byte offsets
    // ******************************************
    localparam logic [ADDR_W-1:0] OFS_OUT_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_INPUT_A_MAP = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_INPUT_B_MAP = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_INPUT_LEVEL = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_MODE_STATUS = 5'h10;

    // ******************************************
    // values after reset
    // ******************************************
    localparam logic [7:0] RST_OUT_CTRL = 8'h00;
    localparam logic [7:0] RST_INPUT_A_MAP = 8'h04;
    localparam logic [7:0] RST_INPUT_B_MAP = 8'h08;
    localparam logic [1:0] RST_INPUT_LEVEL = 2'h0;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    // ******************************************
    // field positions
    // ******************************************
    localparam int LEVEL_A_BIT = 0;
    localparam int LEVEL_B_BIT = 1;

    // ******************************************
    // operating modes, one-hot
    // ******************************************
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b001,
        MODE_LIMP = 3'b010,
        MODE_SLEEP = 3'b100
    } mode_t;

    // ******************************************
    // avalon request carrier
    // ******************************************
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
    } av_req_t;

endpackage
`default_nettype wire

// >>> pin_sync.sv
// two flop synchroniser for asynchronous pins
`default_nettype none
module pin_sync
    import power_switch_ctrl_pkg::*;
#(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // pins and synchronised levels
    input wire logic [WIDTH-1:0] i_pins,
    output logic [WIDTH-1:0] o_levels
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] level_r;

    // first stage feeds only the second stage
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= '0;
            level_r <= '0;
        end else begin
            meta_r <= i_pins;
            level_r <= meta_r;
        end
    end

    assign o_levels = level_r;

endmodule
`default_nettype wire

// >>> bus_handshake.sv
// avalon waitrequest sequencer, one wait cycle per access
`default_nettype none
module bus_handshake (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // request strobes
    input wire logic i_read,
    input wire logic i_write,
    // handshake
    output logic o_waitrequest,
    output logic o_accept,
    output logic o_prefetch
);

    logic ack_r;
    logic busy;

    assign busy = i_read | i_write;
    // first cycle of a request prepares read data
    assign o_prefetch = busy & ~ack_r;
    // second cycle completes it
    assign o_accept = busy & ack_r;
    assign o_waitrequest = busy & ~ack_r;

    // ack alternates so every access takes exactly two cycles
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= o_prefetch;
        end
    end

endmodule
`default_nettype wire

// >>> power_switch_ctrl.sv
// control pins, input mapping and idle mode logic of the power switch
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`default_nettype none
module power_switch_ctrl
    import power_switch_ctrl_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,

    // asynchronous control pins
    input wire logic i_direct_input_a,
    input wire logic i_direct_input_b,
    input wire logic i_idle,
    input wire logic i_supply_ok,

    // avalon-mm register slave
    input wire av_req_t i_av_req,
    output logic o_av_waitrequest,
    output logic [DATA_W-1:0] o_av_readdata,

    // channel drive and power control
    output logic [CHANNELS-1:0] o_channel_drive,
    output logic o_uv_detect_en,
    output logic o_serial_out_oe_n,
    output logic [2:0] o_mode
);

    // ******************************************
    // helper functions
    // ******************************************

    // channels asserted by one input through its map
    function automatic logic [CHANNELS-1:0] mapped_drive(
        input logic [CHANNELS-1:0] map,
        input logic level
    );
        mapped_drive = map & {CHANNELS{level}};
    endfunction

    // byte field of a write, zero extended on read
    function automatic logic [DATA_W-1:0] widen(
        input logic [CHANNELS-1:0] value
    );
        widen = {{(DATA_W-CHANNELS){1'b0}}, value};
    endfunction

    // ******************************************
    // pin synchronisation
    // ******************************************

    logic [3:0] pin_levels;
    logic input_a_level;
    logic input_b_level;
    logic idle_level;
    logic supply_level;

    // all pins pass two flops before anything looks at them
    pin_sync #(
        .WIDTH(4)
    ) u_pin_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_pins({i_supply_ok, i_idle, i_direct_input_b,
            i_direct_input_a}),
        .o_levels(pin_levels)
    );

    assign input_a_level = pin_levels[0];
    assign input_b_level = pin_levels[1];
    assign idle_level = pin_levels[2];
    assign supply_level = pin_levels[3];

    // ******************************************
    // operating mode
    // ******************************************

    mode_t mode_r;
    mode_t mode_nxt;
    logic any_input_high;

    assign any_input_high = input_a_level | input_b_level;

    // the host is trusted to hold idle long enough, so no
    // debounce filter sits here; a glitch is only 2 flops deep
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            MODE_NORMAL: begin
                if (!idle_level && any_input_high) begin
                    mode_nxt = MODE_LIMP;
                end else if (!idle_level) begin
                    mode_nxt = MODE_SLEEP;
                end
            end
            MODE_LIMP: begin
                if (idle_level) begin
                    mode_nxt = MODE_NORMAL;
                end else if (!any_input_high) begin
                    mode_nxt = MODE_SLEEP;
                end
            end
            MODE_SLEEP: begin
                // wake waits for the synchronised idle level
                if (idle_level) begin
                    mode_nxt = MODE_NORMAL;
                end else if (any_input_high) begin
                    mode_nxt = MODE_LIMP;
                end
            end
            default: begin
                mode_nxt = MODE_SLEEP;
            end
        endcase
    end

    // come out of reset asleep until idle or a direct input is seen high
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_r <= MODE_SLEEP;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    logic in_normal;
    logic in_limp;
    logic in_sleep;

    assign in_normal = (mode_r == MODE_NORMAL);
    assign in_limp = (mode_r == MODE_LIMP);
    assign in_sleep = (mode_r == MODE_SLEEP);

    // ******************************************
    // register clear and bus gating
    // ******************************************

    logic regs_clear;
    logic bus_open;

    // idle low or a lost supply forces defaults every cycle
    assign regs_clear = ~idle_level | ~supply_level;
    // answer outside sleep, so limp home can still read levels
    assign bus_open = ~in_sleep & supply_level;

    // ******************************************
    // bus handshake
    // ******************************************

    logic bus_accept;
    logic bus_prefetch;

    // a refused access still completes so the master never hangs
    bus_handshake u_bus_handshake (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_read(i_av_req.read),
        .i_write(i_av_req.write),
        .o_waitrequest(o_av_waitrequest),
        .o_accept(bus_accept),
        .o_prefetch(bus_prefetch)
    );

    // ******************************************
    // address decode
    // ******************************************

    logic hit_out_ctrl;
    logic hit_map_a;
    logic hit_map_b;
    logic hit_level;
    logic hit_mode;

    assign hit_out_ctrl = (i_av_req.address == OFS_OUT_CTRL);
    assign hit_map_a = (i_av_req.address == OFS_INPUT_A_MAP);
    assign hit_map_b = (i_av_req.address == OFS_INPUT_B_MAP);
    assign hit_level = (i_av_req.address == OFS_INPUT_LEVEL);
    assign hit_mode = (i_av_req.address == OFS_MODE_STATUS);

    logic wr_ok;
    logic wr_out_ctrl;
    logic wr_map_a;
    logic wr_map_b;

    // writes land on the completing edge and only when open
    assign wr_ok = bus_accept & i_av_req.write & bus_open;
    assign wr_out_ctrl = wr_ok & hit_out_ctrl;
    assign wr_map_a = wr_ok & hit_map_a;
    assign wr_map_b = wr_ok & hit_map_b;

    // ******************************************
    // software registers
    // ******************************************

    logic [CHANNELS-1:0] out_ctrl_r;
    logic [CHANNELS-1:0] input_a_channel_map_r;
    logic [CHANNELS-1:0] input_b_channel_map_r;
    logic [CHANNELS-1:0] wr_byte;

    assign wr_byte = i_av_req.writedata[CHANNELS-1:0];

    // serial output control bits
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            out_ctrl_r <= RST_OUT_CTRL;
        end else if (regs_clear) begin
            out_ctrl_r <= RST_OUT_CTRL;
        end else if (wr_out_ctrl) begin
            out_ctrl_r <= wr_byte;
        end
    end

    // channel map of input a
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            input_a_channel_map_r <= RST_INPUT_A_MAP;
        end else if (regs_clear) begin
            input_a_channel_map_r <= RST_INPUT_A_MAP;
        end else if (wr_map_a) begin
            input_a_channel_map_r <= wr_byte;
        end
    end

    // channel map of input b
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            input_b_channel_map_r <= RST_INPUT_B_MAP;
        end else if (regs_clear) begin
            input_b_channel_map_r <= RST_INPUT_B_MAP;
        end else if (wr_map_b) begin
            input_b_channel_map_r <= wr_byte;
        end
    end

    // ******************************************
    // input level monitor
    // ******************************************

    logic [1:0] input_level_monitor_r;

    // tracks the pins in every mode, limp home included
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            input_level_monitor_r <= RST_INPUT_LEVEL;
        end else begin
            input_level_monitor_r[LEVEL_A_BIT] <= input_a_level;
            input_level_monitor_r[LEVEL_B_BIT] <= input_b_level;
        end
    end

    // ******************************************
    // read data
    // ******************************************

    logic [DATA_W-1:0] rd_sel;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] readdata_r;

    // unmapped offsets read as zero
    assign rd_sel = hit_out_ctrl ? widen(out_ctrl_r) :
        hit_map_a ? widen(input_a_channel_map_r) :
        hit_map_b ? widen(input_b_channel_map_r) :
        hit_level ? {30'h0, input_level_monitor_r} :
        hit_mode ? {29'h0, mode_r} :
        READ_ZERO;
    // a refused read returns zero instead of register state
    assign rd_word = bus_open ? rd_sel : READ_ZERO;

    // captured one cycle early so it stands on the completing edge
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            readdata_r <= READ_ZERO;
        end else if (bus_prefetch && i_av_req.read) begin
            readdata_r <= rd_word;
        end
    end

    assign o_av_readdata = readdata_r;

    // ******************************************
    // channel drive
    // ******************************************

    logic [CHANNELS-1:0] normal_drive;
    logic [CHANNELS-1:0] limp_drive;
    logic [CHANNELS-1:0] drive_nxt;
    logic [CHANNELS-1:0] drive_r;

    // serial bits or-ed with every mapped input
    assign normal_drive = out_ctrl_r
        | mapped_drive(input_a_channel_map_r, input_a_level)
        | mapped_drive(input_b_channel_map_r, input_b_level);
    // limp home uses fixed default maps, never programmed ones
    assign limp_drive =
        mapped_drive(RST_INPUT_A_MAP, input_a_level)
        | mapped_drive(RST_INPUT_B_MAP, input_b_level);
    // sleep switches every channel off
    assign drive_nxt = in_normal ? normal_drive :
        in_limp ? limp_drive : '0;

    // registered so the power stage never sees decode glitches
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            drive_r <= '0;
        end else begin
            drive_r <= drive_nxt;
        end
    end

    assign o_channel_drive = drive_r;

    // ******************************************
    // power and serial pin control
    // ******************************************

    logic uv_en_r;
    logic so_oe_n_r;

    // detectors off and data output released only in sleep
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            uv_en_r <= 1'b1;
            so_oe_n_r <= 1'b1;
        end else begin
            uv_en_r <= ~(mode_nxt == MODE_SLEEP);
            so_oe_n_r <= (mode_nxt == MODE_SLEEP);
        end
    end

    assign o_uv_detect_en = uv_en_r;
    assign o_serial_out_oe_n = so_oe_n_r;
    assign o_mode = mode_r;

endmodule
`default_nettype wire

// >>> pwr_ctrl_chk.sv
// assertions on mode, channel drive and bus answer of the control block
`default_nettype none
module pwr_ctrl_chk
    import power_switch_ctrl_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // pins and bus request
    input wire logic i_direct_input_a,
    input wire logic i_direct_input_b,
    input wire logic i_idle,
    input wire av_req_t i_av_req,
    // watched outputs
    input wire logic o_av_waitrequest,
    input wire logic [DATA_W-1:0] o_av_readdata,
    input wire logic [CHANNELS-1:0] o_channel_drive,
    input wire logic o_uv_detect_en,
    input wire logic o_serial_out_oe_n,
    input wire logic [2:0] o_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // helpers
    // ****
    logic [2:0] pins_q;
    logic [2:0] age;
    logic [2:0] exp_mode;
    logic [7:0] dflt;
    wire logic req = i_av_req.read | i_av_req.write;
    wire logic [2:0] pins = {i_idle, i_direct_input_b, i_direct_input_a};
    wire logic rd_done = i_av_req.read & ~o_av_waitrequest;
    // expectations use the previous pin sample: outputs lag the pins
    assign exp_mode = pins_q[2] ? MODE_NORMAL :
        (pins_q[1:0] != 2'b00) ? MODE_LIMP : MODE_SLEEP;
    assign dflt = (RST_INPUT_A_MAP & {8{pins_q[0]}})
                | (RST_INPUT_B_MAP & {8{pins_q[1]}});
    // cycles the pins stayed put; covers sync latency with margin
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pins_q <= 3'h0;
            age <= 3'h0;
        end else begin
            pins_q <= pins;
            age <= (pins != pins_q) ? 3'h0 : (age == 3'h7 ? age : age + 3'h1);
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // ****
    // assertions
    // ****
    mode_pins_a: assert property (
        age >= 3'h5 |-> o_mode == exp_mode) else $error("mode not from pins");
    uv_sleep_a: assert property (
        $past(i_rst_n) |-> o_uv_detect_en == (o_mode != MODE_SLEEP))
        else $error("uv enable wrong for mode");
    so_release_a: assert property (
        o_mode == MODE_SLEEP |-> o_serial_out_oe_n) else $error("so driven");
    limp_drive_a: assert property (
        age >= 3'h5 && o_mode != MODE_NORMAL |->
        o_channel_drive == CHANNELS'(dflt)) else $error("idle drive wrong");
    wait_first_a: assert property (
        $rose(req) |-> o_av_waitrequest ##1 (!o_av_waitrequest || !req))
        else $error("bus answer timing wrong");
    accept_once_a: assert property (
        req && !o_av_waitrequest |=> o_av_waitrequest || !req)
        else $error("second accept");
    sleep_read_a: assert property (
        rd_done && $past(o_mode) == MODE_SLEEP |-> o_av_readdata == READ_ZERO)
        else $error("read served in sleep");
    level_read_a: assert property (
        rd_done && i_av_req.address == OFS_INPUT_LEVEL && age >= 3'h5 |->
        o_av_readdata == DATA_W'(pins_q[1:0])) else $error("level read wrong");
    // main scenarios
    cover property (o_mode == MODE_LIMP && age >= 3'h5);
    cover property (o_mode == MODE_SLEEP && age >= 3'h5);
    cover property (i_av_req.write && !o_av_waitrequest);
endmodule
bind power_switch_ctrl pwr_ctrl_chk #(.CHANNELS(CHANNELS)) u_chk (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_idle(i_idle),
    .i_direct_input_a(i_direct_input_a), .i_av_req(i_av_req),
    .i_direct_input_b(i_direct_input_b), .o_mode(o_mode),
    .o_av_waitrequest(o_av_waitrequest), .o_av_readdata(o_av_readdata),
    .o_channel_drive(o_channel_drive), .o_uv_detect_en(o_uv_detect_en),
    .o_serial_out_oe_n(o_serial_out_oe_n));
`default_nettype wire

// >>> host_pins.sv
// host model driving the direct inputs and the idle pin
`default_nettype none
module host_pins #(
    parameter int HOLD = 8
) (
    // clock
    input wire logic i_core_clk,
    // wanted levels {idle, b, a}
    input wire logic [2:0] i_cmd,
    // pins and hold status
    output logic o_idle,
    output logic o_in_a,
    output logic o_in_b,
    output logic o_settled
);
    timeunit 1ns;
    timeprecision 1ps;
    int hold_cnt = 0;
    logic idle_r = 1'b0;
    logic [1:0] in_r = 2'b00;
    // idle level kept HOLD cycles, else a mode change may be lost
    always @(posedge i_core_clk) begin
        in_r <= i_cmd[1:0];
        if (i_cmd[2] != idle_r && hold_cnt >= HOLD) begin
            idle_r <= i_cmd[2];
            hold_cnt <= 0;
        end else if (hold_cnt < HOLD) begin
            hold_cnt <= hold_cnt + 1;
        end
    end
    assign o_idle = idle_r;
    assign o_in_a = in_r[0];
    assign o_in_b = in_r[1];
    assign o_settled = (hold_cnt >= HOLD) && (idle_r == i_cmd[2]);
endmodule
`default_nettype wire

// >>> tb_top.sv
// testbench of the control pin block
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top
    import power_switch_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [2:0] cmd = 3'b000;
    av_req_t req = '0;
    logic idle, in_a, in_b, settled, waitreq, uv_en, oe_n;
    logic [DATA_W-1:0] rdata, d;
    logic [7:0] drive;
    logic [2:0] mode;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    always #2.5 i_core_clk = ~i_core_clk;
    host_pins u_host (.i_core_clk(i_core_clk), .i_cmd(cmd), .o_idle(idle),
        .o_in_a(in_a), .o_in_b(in_b), .o_settled(settled));
    // supply held good: supply faults lie outside these tests
    power_switch_ctrl u_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_direct_input_a(in_a), .i_direct_input_b(in_b), .i_idle(idle),
        .i_supply_ok(1'b1), .i_av_req(req), .o_av_waitrequest(waitreq),
        .o_av_readdata(rdata), .o_channel_drive(drive),
        .o_uv_detect_en(uv_en), .o_serial_out_oe_n(oe_n), .o_mode(mode));
    // ****
    // tasks
    // ****
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // one access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge i_core_clk);
        req <= '{read: !wr, write: wr, address: a, writedata: DATA_W'(wd)};
        do begin
            @(posedge i_core_clk);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        d = rdata;
        req <= '0;
        `CHK("bus answer", 1'b0, waitreq)
    endtask
    task automatic rd(input string nm, input logic [ADDR_W-1:0] a,
                      input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK(nm, DATA_W'(e), d)
    endtask
    // pins then outputs after the sync latency
    task automatic pins(input logic [2:0] c, input logic [7:0] dr,
                        input logic [2:0] md);
        int n;
        n = 0;
        @(posedge i_core_clk);
        cmd <= c;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (!settled && n < 50);
        repeat (6) @(posedge i_core_clk);
        `CHK("drive", dr, drive)
        `CHK("mode", md, mode)
        `CHK("uv enable", 1'(md != MODE_SLEEP), uv_en)
        `CHK("so release", 1'(md == MODE_SLEEP), oe_n)
    endtask
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            results();
        end
    end
    // ****
    // tests
    // ****
    initial begin
        repeat (3) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        pins(3'b100, 8'h00, MODE_NORMAL);
        rd("a map", OFS_INPUT_A_MAP, 8'h04);
        rd("b map", OFS_INPUT_B_MAP, 8'h08);
        rd("out", OFS_OUT_CTRL, 8'h00);
        rd("unmapped", 5'h14, 8'h00);
        rd("mode", OFS_MODE_STATUS, 8'h01);
        $display("test defaults done");
        pins(3'b101, 8'h04, MODE_NORMAL);
        pins(3'b111, 8'h0c, MODE_NORMAL);
        rd("level", OFS_INPUT_LEVEL, 8'h03);
        $display("test default map done");
        bus(1'b1, OFS_INPUT_A_MAP, 8'h81);
        bus(1'b1, OFS_INPUT_B_MAP, 8'h30);
        bus(1'b1, OFS_OUT_CTRL, 8'h02);
        bus(1'b1, OFS_INPUT_LEVEL, 8'hff);
        pins(3'b101, 8'h83, MODE_NORMAL);
        pins(3'b110, 8'h32, MODE_NORMAL);
        pins(3'b111, 8'hb3, MODE_NORMAL);
        rd("a map", OFS_INPUT_A_MAP, 8'h81);
        rd("level", OFS_INPUT_LEVEL, 8'h03);
        $display("test remap done");
        pins(3'b001, 8'h04, MODE_LIMP);
        rd("level", OFS_INPUT_LEVEL, 8'h01);
        rd("mode", OFS_MODE_STATUS, 8'h02);
        pins(3'b010, 8'h08, MODE_LIMP);
        rd("level", OFS_INPUT_LEVEL, 8'h02);
        pins(3'b110, 8'h08, MODE_NORMAL);
        rd("a map", OFS_INPUT_A_MAP, 8'h04);
        rd("out", OFS_OUT_CTRL, 8'h00);
        $display("test limp done");
        pins(3'b000, 8'h00, MODE_SLEEP);
        bus(1'b1, OFS_OUT_CTRL, 8'hff);
        rd("out", OFS_OUT_CTRL, 8'h00);
        pins(3'b100, 8'h00, MODE_NORMAL);
        rd("out", OFS_OUT_CTRL, 8'h00);
        $display("test sleep done");
        results();
    end
endmodule
`default_nettype wire
